/* hw/traj_map.vh */
// constants shared by the trajectory and position logic
`ifndef TRAJ_MAP_VH
`define TRAJ_MAP_VH

// ****************************************
// command codes written to the command port
// ****************************************
`define CMD_LOAD_TRAJ 8'h1F
`define CMD_START 8'h01

// ****************************************
// register byte addresses on the bus
// ****************************************
`define ADDR_CMD 5'h00
`define ADDR_DATA 5'h04
`define ADDR_ACT_POS 5'h08
`define ADDR_SAMPLE_POS 5'h0C
`define ADDR_DESIRED 5'h10
`define ADDR_CTRL 5'h14

// ****************************************
// status bits read at the command address
// ****************************************
`define ST_BUSY 0
`define ST_RUN 1
`define ST_LOAD 2
`define ST_DRIVE 3

// ****************************************
// trajectory control word fields
// ****************************************
`define CW_POS_REL 0
`define CW_POS_LOAD 1
`define CW_VEL_REL 2
`define CW_VEL_LOAD 3
`define CW_ACC_REL 4
`define CW_ACC_LOAD 5
`define CW_MOTOR_OFF 8
`define CW_STOP_ABRUPT 9
`define CW_STOP_SMOOTH 10
`define CW_VEL_MODE 11
`define CW_FORWARD 12

// ****************************************
// timing and number format
// ****************************************
`define BUSY_CYCLES 4'h4
`define SAMPLE_CYCLES 2048
`define SAMPLE_W 11
`define FRAC_ZERO 16'h0000

`endif

/* hw/quad_position_counter.v */
// quadrature decoder with pin synchronisers and absolute position counter
`timescale 1ns/10ps
`include "traj_map.vh"

module quad_position_counter (
  input wire clock, // system clock
  input wire reset, // asynchronous reset, active high
  input wire enc_a, // encoder channel a pin
  input wire enc_b, // encoder channel b pin
  output reg [31:0] position_q // absolute position in counts
);

  // ****************************************
  // pin synchronisers, three stages per channel
  // ****************************************
  wire [1:0] pins; // {a, b}
  reg [1:0] filt_q; // filtered channel state {a, b}
  wire [1:0] filt_d; // next filtered state
  assign pins = {enc_a, enc_b};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : sync
      reg s1_q; // first stage, read only by s2_q
      reg s2_q; // second stage
      reg s3_q; // third stage
      // shift the pin through three flops
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pins[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // a change counts only once stages two and three agree
      assign filt_d[i] = (s2_q == s3_q) ? s3_q : filt_q[i];
    end
  endgenerate

  // ****************************************
  // state decode and count
  // ****************************************
  wire one_step; // exactly one channel changed
  wire count_up; // channel a leads channel b
  assign one_step = ^(filt_d ^ filt_q); // R8
  // forward order 00-10-11-01: new a differs from old b
  assign count_up = filt_d[1] ^ filt_q[0]; // R10

  // both channels moving at once is a lost step, so it is ignored
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      filt_q <= 2'h0;
      position_q <= 32'h0000_0000; // R18
    end else begin
      filt_q <= filt_d;
      if (one_step) begin
        if (count_up) begin
          position_q <= position_q + 32'h0000_0001; // R9
        end else begin
          position_q <= position_q - 32'h0000_0001; // R9
        end
      end
    end
  end

endmodule

/* hw/trajectory_load_quadrature_position.v */
// trajectory loading, start of motion and position feedback core
// How it works
// R1: host sends load command, control word, data
// R2: upper byte zero selects position mode
// R3: lower byte zero means no data words
// R4: start copies buffers to working registers
// R5: buffered values idle until start
// R6: zero acceleration holds current absolute position
// R7: position comes from quadrature encoder decoding
// R8: four states per channel cycle
// R9: each adjacent transition moves count by one
// R10: leading channel sets counting direction
// R11: position sampled every 2048 clocks
// R12: velocity, acceleration use sample period units
// R13: absolute move ends exactly at target
// R14: bits eight to ten pick stop mode
// R15: motor-off, abrupt and smooth stop behaviours
// R16: parameters arrive as high word first
// R17: host waits for busy clear
// R18: reset clears counter, buffers, working registers
`timescale 1ns/10ps
`include "traj_map.vh"

module trajectory_load_quadrature_position #(
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES, // clocks per sample period
  parameter SAMPLE_W = `SAMPLE_W // width of the sample counter
) (
  input wire clock, // 10 MHz system clock
  input wire reset, // asynchronous reset, active high
  input wire [4:0] address, // avalon byte address
  input wire read, // avalon read request
  input wire write, // avalon write request
  input wire [31:0] writedata, // avalon write data
  output wire [31:0] readdata, // avalon read data
  output wire waitrequest, // avalon wait, low when answered
  input wire enc_a, // encoder channel a
  input wire enc_b, // encoder channel b
  output wire [31:0] desired_position, // profile output, counts
  output wire motor_drive_enable, // low forces zero drive
  output wire sample_tick // one-cycle pulse per sample
);

  // ****************************************
  // load state machine codes
  // ****************************************
  localparam LD_IDLE = 2'b00; // no load in progress
  localparam LD_CTRL = 2'b01; // waiting for control word
  localparam LD_DATA = 2'b10; // waiting for parameter words

  // first parameter still pending, in acc, vel, pos order
  function [2:0] first_param;
    input [2:0] m;
    begin
      if (m[2]) begin
        first_param = 3'h4;
      end else if (m[1]) begin
        first_param = 3'h2;
      end else begin
        first_param = {2'h0, m[0]};
      end
    end
  endfunction

  // ****************************************
  // position feedback
  // ****************************************
  wire [31:0] act_pos; // live absolute position
  reg [SAMPLE_W-1:0] samp_cnt_q; // sample period counter
  reg tick_q; // registered sample pulse
  reg [31:0] sample_pos_q; // position at last sample
  wire tick; // last clock of the sample period

  // R7
  quad_position_counter decoder (
    .clock(clock),
    .reset(reset),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .position_q(act_pos)
  );

  assign tick = (samp_cnt_q == SAMPLE_CYCLES[SAMPLE_W-1:0] - 1'b1);

  // free running period counter; also the profile time base
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      samp_cnt_q <= {SAMPLE_W{1'b0}};
      tick_q <= 1'b0;
      sample_pos_q <= 32'h0000_0000;
    end else begin
      tick_q <= tick;
      if (tick) begin
        samp_cnt_q <= {SAMPLE_W{1'b0}}; // R11
        sample_pos_q <= act_pos; // R11
      end else begin
        samp_cnt_q <= samp_cnt_q + 1'b1;
      end
    end
  end
  assign sample_tick = tick_q;

  // ****************************************
  // bus slave: one wait cycle per access
  // ****************************************
  reg ack_q; // answer cycle
  reg [31:0] rdata_q; // registered read data
  reg [3:0] busy_q; // busy countdown
  wire wr_go; // write takes effect this edge
  wire busy; // device ignores command and data writes
  wire cmd_ok; // accepted command write
  wire data_ok; // accepted data write
  reg [31:0] rd_mux; // read selection

  assign waitrequest = (read | write) & ~ack_q;
  assign readdata = rdata_q;
  assign wr_go = write & ack_q;
  assign busy = (busy_q != 4'h0);
  // writes during busy are dropped, as the host is to wait
  assign cmd_ok = wr_go & (address == `ADDR_CMD) & ~busy; // R17
  assign data_ok = wr_go & (address == `ADDR_DATA) & ~busy; // R17

  // profile and load registers, declared ahead of the read mux
  reg [1:0] ld_state_q; // load state
  reg [2:0] pend_q; // parameters still to arrive
  reg half_q; // high word already taken
  reg [15:0] hi_word_q; // held high word
  reg [15:0] ctrl_buf_q; // buffered control word
  reg ctrl_fresh_q; // control word loaded since start
  reg [2:0] fresh_q; // parameters loaded since start
  reg [31:0] acc_buf_q; // buffered acceleration
  reg [31:0] vel_buf_q; // buffered velocity
  reg [31:0] pos_buf_q; // buffered position
  reg [15:0] ctrl_w_q; // working control word
  reg [31:0] acc_w_q; // working acceleration, 16.16
  reg [31:0] vel_w_q; // working velocity, 16.16
  reg [31:0] target_q; // working target position
  reg run_q; // profile in motion
  reg decel_q; // smooth stop under way
  reg drive_on_q; // drive enabled
  reg dir_q; // moving forward
  reg [47:0] dpos_q; // desired position, 32.16
  reg [31:0] vel_q; // present velocity, 16.16
  reg [47:0] brake_q; // distance built up while speeding up

  // read decode; unmapped addresses read zero
  always @* begin
    case (address)
      `ADDR_CMD: begin
        rd_mux = 32'h0000_0000;
        rd_mux[`ST_BUSY] = busy;
        rd_mux[`ST_RUN] = run_q;
        rd_mux[`ST_LOAD] = (ld_state_q != LD_IDLE);
        rd_mux[`ST_DRIVE] = drive_on_q;
      end
      `ADDR_ACT_POS: rd_mux = act_pos;
      `ADDR_SAMPLE_POS: rd_mux = sample_pos_q;
      `ADDR_DESIRED: rd_mux = dpos_q[47:16];
      `ADDR_CTRL: rd_mux = {16'h0000, ctrl_w_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // answer one cycle after the request; busy follows each accepted write
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      busy_q <= 4'h0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
      if (read & ~ack_q) begin
        rdata_q <= rd_mux;
      end
      if (cmd_ok | data_ok) begin
        busy_q <= `BUSY_CYCLES;
      end else if (busy) begin
        busy_q <= busy_q - 4'h1;
      end
    end
  end

  // ****************************************
  // trajectory load into input buffers
  // ****************************************
  wire start_go; // start command accepted
  wire load_go; // load command accepted
  wire [2:0] sel; // parameter taking this word
  wire [2:0] pend_left; // pending after this word
  wire [2:0] ctrl_load; // load flags in a control word
  assign load_go = cmd_ok & (writedata[7:0] == `CMD_LOAD_TRAJ); // R1
  assign start_go = cmd_ok & (writedata[7:0] == `CMD_START);
  assign sel = first_param(pend_q);
  assign pend_left = pend_q & ~sel;
  assign ctrl_load = {writedata[`CW_ACC_LOAD], writedata[`CW_VEL_LOAD],
    writedata[`CW_POS_LOAD]};

  // a new load command restarts the sequence mid-way
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ld_state_q <= LD_IDLE;
      pend_q <= 3'h0;
      half_q <= 1'b0;
      hi_word_q <= 16'h0000;
      ctrl_buf_q <= 16'h0000; // R18
      ctrl_fresh_q <= 1'b0;
      fresh_q <= 3'h0;
      acc_buf_q <= 32'h0000_0000; // R18
      vel_buf_q <= 32'h0000_0000; // R18
      pos_buf_q <= 32'h0000_0000; // R18
    end else if (load_go) begin
      ld_state_q <= LD_CTRL;
      half_q <= 1'b0;
    end else if (start_go) begin
      // buffers are consumed by the start
      ctrl_fresh_q <= 1'b0;
      fresh_q <= 3'h0;
    end else if (data_ok) begin
      case (ld_state_q)
        LD_CTRL: begin
          ctrl_buf_q <= writedata[15:0];
          ctrl_fresh_q <= 1'b1;
          pend_q <= ctrl_load;
          // lower byte of zero: no parameter words follow
          ld_state_q <= (ctrl_load == 3'h0) ? LD_IDLE : LD_DATA; // R3
        end
        LD_DATA: begin
          if (!half_q) begin
            hi_word_q <= writedata[15:0]; // R16
            half_q <= 1'b1;
          end else begin
            half_q <= 1'b0;
            pend_q <= pend_left;
            fresh_q <= fresh_q | sel;
            if (sel[2]) begin
              acc_buf_q <= {hi_word_q, writedata[15:0]}; // R16
            end
            if (sel[1]) begin
              vel_buf_q <= {hi_word_q, writedata[15:0]}; // R16
            end
            if (sel[0]) begin
              pos_buf_q <= {hi_word_q, writedata[15:0]}; // R16
            end
            if (pend_left == 3'h0) begin
              ld_state_q <= LD_IDLE;
            end
          end
        end
        default: ld_state_q <= LD_IDLE; // stray data word ignored
      endcase
    end
  end

  // ****************************************
  // values a start would install
  // ****************************************
  wire [15:0] ctrl_n; // control word after start
  wire [31:0] acc_n; // acceleration after start
  wire [31:0] vel_n; // velocity after start
  wire [31:0] target_n; // target after start
  wire vel_mode_n; // velocity mode after start
  // only freshly loaded values replace working ones
  assign ctrl_n = ctrl_fresh_q ? ctrl_buf_q : ctrl_w_q; // R5
  assign acc_n = !fresh_q[2] ? acc_w_q :
    (ctrl_n[`CW_ACC_REL] ? acc_w_q + acc_buf_q : acc_buf_q); // R5
  assign vel_n = !fresh_q[1] ? vel_w_q :
    (ctrl_n[`CW_VEL_REL] ? vel_w_q + vel_buf_q : vel_buf_q); // R5
  // absolute target is measured from zero, wherever the shaft is
  assign target_n = !fresh_q[0] ? target_q :
    (ctrl_n[`CW_POS_REL] ? target_q + pos_buf_q : pos_buf_q); // R13
  // upper byte clear means position mode
  assign vel_mode_n = ctrl_n[`CW_VEL_MODE]; // R2

  // ****************************************
  // profile generator, stepped once per sample
  // ****************************************
  wire [47:0] vel48; // velocity as 32.16 step
  wire [47:0] acc48; // acceleration as 32.16
  wire [47:0] diff; // target minus desired
  wire [47:0] rem; // distance left
  wire vel_mode; // working mode
  assign vel48 = {16'h0000, vel_q};
  assign acc48 = {16'h0000, acc_w_q};
  assign diff = {target_q, `FRAC_ZERO} - dpos_q;
  assign rem = diff[47] ? (48'h0 - diff) : diff;
  assign vel_mode = ctrl_w_q[`CW_VEL_MODE];
  assign desired_position = dpos_q[47:16];
  assign motor_drive_enable = drive_on_q;

  // stop bits act only on the start that follows their load
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_w_q <= 16'h0000; // R18
      acc_w_q <= 32'h0000_0000; // R18
      vel_w_q <= 32'h0000_0000; // R18
      target_q <= 32'h0000_0000; // R18
      run_q <= 1'b0;
      decel_q <= 1'b0;
      drive_on_q <= 1'b1;
      dir_q <= 1'b1;
      dpos_q <= 48'h0;
      vel_q <= 32'h0000_0000;
      brake_q <= 48'h0;
    end else if (start_go) begin
      ctrl_w_q <= ctrl_n; // R4
      acc_w_q <= acc_n; // R4
      vel_w_q <= vel_n; // R4
      target_q <= target_n; // R4
      drive_on_q <= 1'b1;
      decel_q <= 1'b0;
      if (ctrl_fresh_q && ctrl_n[`CW_MOTOR_OFF]) begin
        drive_on_q <= 1'b0; // R14
        run_q <= 1'b0;
        vel_q <= 32'h0000_0000;
      end else if (ctrl_fresh_q && ctrl_n[`CW_STOP_ABRUPT]) begin
        // target becomes the present position at once
        target_q <= act_pos; // R15
        dpos_q <= {act_pos, `FRAC_ZERO}; // R15
        run_q <= 1'b0;
        vel_q <= 32'h0000_0000;
      end else if (ctrl_fresh_q && ctrl_n[`CW_STOP_SMOOTH]) begin
        decel_q <= run_q; // R14
      end else if (acc_n == 32'h0000_0000) begin
        // nothing to ramp with: hold where the shaft is
        dpos_q <= {act_pos, `FRAC_ZERO}; // R6
        run_q <= 1'b0;
        vel_q <= 32'h0000_0000;
      end else begin
        dpos_q <= {act_pos, `FRAC_ZERO}; // R4
        run_q <= 1'b1;
        vel_q <= 32'h0000_0000;
        brake_q <= 48'h0;
        dir_q <= vel_mode_n ? ctrl_n[`CW_FORWARD] :
          ($signed(target_n) > $signed(act_pos));
      end
    end else if (!drive_on_q) begin
      // motor off: desired follows actual, so the drive stays zero
      dpos_q <= {act_pos, `FRAC_ZERO}; // R15
    end else if (run_q && tick) begin
      // one sample period is one time unit for vel and acc
      if (!vel_mode && !decel_q && rem <= vel48) begin
        dpos_q <= {target_q, `FRAC_ZERO}; // R13
        vel_q <= 32'h0000_0000;
        run_q <= 1'b0;
      end else begin
        if (dir_q) begin
          dpos_q <= dpos_q + vel48; // R12
        end else begin
          dpos_q <= dpos_q - vel48; // R12
        end
        if (decel_q || (!vel_mode && rem <= brake_q)) begin
          if (vel_q > acc_w_q) begin
            vel_q <= vel_q - acc_w_q; // R15
            brake_q <= (brake_q > vel48) ? brake_q - vel48 : 48'h0;
          end else if (decel_q) begin
            // smooth stop done: hold where the profile ended
            vel_q <= 32'h0000_0000; // R15
            run_q <= 1'b0;
            decel_q <= 1'b0;
            target_q <= dpos_q[47:16];
          end else begin
            // creep at one step so the target is always reached
            vel_q <= acc_w_q;
          end
        end else if (vel_q + acc_w_q <= vel_w_q) begin
          vel_q <= vel_q + acc_w_q; // R12
          brake_q <= brake_q + vel48 + acc48;
        end else begin
          vel_q <= vel_w_q;
        end
      end
    end
  end

endmodule

/* verif/trajectory_load_quadrature_position_properties.sv */
// port-level checks for the trajectory and position core
`timescale 1ns/10ps

module traj_checker #(
  parameter SAMPLE_CYCLES = 2048, // clocks per sample period
  parameter SAMPLE_W = 11 // sample counter width
) (
  input wire clock, // system clock
  input wire reset, // asynchronous reset
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata, // bus read data
  input wire waitrequest, // bus wait
  input wire enc_a,
  input wire enc_b,
  input wire [31:0] desired_position, // profile output
  input wire motor_drive_enable, // drive on
  input wire sample_tick // sample pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ****************************************
  // tick spacing helper
  // ****************************************
  reg [15:0] gap_q; // clocks since the last tick
  reg seen_q; // set once a tick has passed
  // first interval after reset not judged
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (sample_tick) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  wait_first_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after wait");
  wait_idle_a: assert property (!read && !write |-> !waitrequest)
    else $error("idle wait");
  readdata_hold_a: assert property ($changed(readdata) |-> read && $past(read))
    else $error("read data moved");
  tick_period_a: assert property (sample_tick && seen_q |-> gap_q == SAMPLE_CYCLES - 1)
    else $error("tick period");
  tick_gap_a: assert property (seen_q |-> gap_q < SAMPLE_CYCLES)
    else $error("tick missing");
  tick_pulse_a: assert property (sample_tick |=> !sample_tick)
    else $error("tick too long");
  track_step_a: assert property (!motor_drive_enable && !$past(motor_drive_enable)
    && desired_position != $past(desired_position) |->
    (desired_position - $past(desired_position) == 32'h1) ||
    ($past(desired_position) - desired_position == 32'h1))
    else $error("tracking jump");
  drive_cause_a: assert property ($changed(motor_drive_enable) |->
    $past(write, 1) || $past(write, 2) || $past(write, 3))
    else $error("drive change uncaused");
  reset_zero_a: assert property ($fell(reset) |-> desired_position == 32'h0
    && motor_drive_enable && !sample_tick)
    else $error("reset values");

  // ****************************************
  // coverage
  // ****************************************
  tick_c: cover property (sample_tick && seen_q);
  off_c: cover property ($fell(motor_drive_enable));
  answer_c: cover property (read && !waitrequest);
endmodule

bind trajectory_load_quadrature_position traj_checker #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES), .SAMPLE_W(SAMPLE_W)) chk (.clock(clock), .reset(reset),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .enc_a(enc_a), .enc_b(enc_b),
  .desired_position(desired_position), .motor_drive_enable(motor_drive_enable),
  .sample_tick(sample_tick));

/* verif/host_bus_model.sv */
// host model: bus master that loads trajectories and polls busy
`timescale 1ns/10ps
`include "traj_map.vh"

module host_bus_model (
  input wire clock, // system clock
  input wire waitrequest, // slave wait
  input wire [31:0] readdata, // slave read data
  output logic [4:0] address = 5'h00, // request address
  output logic read = 1'b0, // read request
  output logic write = 1'b0, // write request
  output logic [31:0] writedata = 32'h0 // write data
);
  // one access, held up to the edge that samples wait low
  task automatic xfer(input bit wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    begin
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
        @(negedge clock);
      end while (waitrequest !== 1'b0);
      @(posedge clock);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
    end
  endtask

  // write once busy has cleared
  task automatic put(input logic [4:0] a, input logic [15:0] w);
    logic [31:0] s;
    begin
      do begin
        xfer(1'b0, `ADDR_CMD, 32'h0, s);
      end while (s[`ST_BUSY] !== 1'b0);
      xfer(1'b1, a, {16'h0000, w}, s);
    end
  endtask

  // command, control word, flagged parameters
  task automatic load_traj(input logic [15:0] cw, input logic [31:0] acc, vel, pos);
    logic [31:0] par [3];
    begin
      par = '{acc, vel, pos};
      put(`ADDR_CMD, {8'h00, `CMD_LOAD_TRAJ});
      put(`ADDR_DATA, cw);
      for (int i = 0; i < 3; i++) begin
        if (cw[5 - 2 * i]) begin
          put(`ADDR_DATA, par[i][31:16]);
          put(`ADDR_DATA, par[i][15:0]);
        end
      end
    end
  endtask

  // start command
  task automatic start_move;
    put(`ADDR_CMD, {8'h00, `CMD_START});
  endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the trajectory and position core
`timescale 1ns/10ps
`include "traj_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb;
  localparam int SC = 16; // short sample period keeps the run brief
  logic clock = 1'b0; // system clock
  logic reset = 1'b1; // active high reset
  logic enc_a = 1'b0; // encoder channel a
  logic enc_b = 1'b0; // encoder channel b
  wire [4:0] address; // bus address
  wire read; // bus read
  wire write; // bus write
  wire [31:0] writedata; // bus write data
  wire [31:0] readdata; // bus read data
  wire waitrequest; // bus wait
  wire [31:0] desired_position; // profile output
  wire motor_drive_enable; // drive on
  wire sample_tick; // sample pulse
  int error_cnt = 0; // mismatches
  int n_checks = 0; // comparisons
  int idx = 0; // quadrature state index
  int n; // random step count
  logic [31:0] pos_exp = 32'h0; // expected live count
  logic [31:0] tgt; // move target
  logic [31:0] rd; // scratch read data
  logic [15:0] stop_cw [3] = '{16'h0200, 16'h0400, 16'h0100}; // abrupt, smooth, off
  logic [31:0] drv_exp [3] = '{32'h8, 32'h8, 32'h0}; // drive bit after each stop
  typedef struct {string nm; logic [31:0] m; logic [31:0] v;} note_t;
  note_t notes[$]; // expected read results, oldest first

  always #50 clock = ~clock;

  host_bus_model host (.clock(clock), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata));
  trajectory_load_quadrature_position #(.SAMPLE_CYCLES(SC), .SAMPLE_W(4)) dut (
    .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .enc_a(enc_a), .enc_b(enc_b), .desired_position(desired_position),
    .motor_drive_enable(motor_drive_enable), .sample_tick(sample_tick));

  // answered reads meet the oldest note
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0 && notes.size() > 0) begin
      `CHK(notes[0].nm, notes[0].v, readdata & notes[0].m)
      void'(notes.pop_front());
    end
  end

  // note, then read back
  task automatic check_read(input string nm, input logic [4:0] a, input logic [31:0] v,
                            input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    begin
      notes.push_back('{nm, m, v & m});
      host.xfer(1'b0, a, 32'h0, q);
    end
  endtask

  // one quadrature step, held six clocks
  task automatic enc_step(input bit up);
    begin
      idx = up ? (idx + 1) % 4 : (idx + 3) % 4;
      enc_a <= (idx == 1 || idx == 2);
      enc_b <= (idx >= 2);
      pos_exp = up ? pos_exp + 32'h1 : pos_exp - 32'h1;
      repeat (6) @(posedge clock);
    end
  endtask

  // print counts and verdict, then stop
  task automatic finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // watchdog: the tests need about a thousand clocks
  initial begin
    repeat (50000) @(posedge clock);
    error_cnt++;
    $display("[FAIL] watchdog expired");
    finish_test();
  end

  initial begin
    void'($urandom(43800));
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check_read("live count", `ADDR_ACT_POS, 32'h0);
    check_read("desired", `ADDR_DESIRED, 32'h0);
    check_read("working word", `ADDR_CTRL, 32'h0);
    check_read("drive bit", `ADDR_CMD, 32'h8, 32'h8);
    check_read("unmapped", 5'h1C, 32'h0);
    $display("test reset done");
    // ****************************************
    // encoder counting both ways and the sample latch
    // ****************************************
    for (int i = 0; i < 4; i++) enc_step(1'b1);
    check_read("one cycle", `ADDR_ACT_POS, 32'h4);
    n = 1 + $urandom % 12;
    for (int i = 0; i < n; i++) enc_step(1'b1);
    check_read("count up", `ADDR_ACT_POS, pos_exp);
    n = 1 + $urandom % 30;
    for (int i = 0; i < n; i++) enc_step(1'b0);
    check_read("count down", `ADDR_ACT_POS, pos_exp);
    enc_a <= ~enc_a;
    enc_b <= ~enc_b;
    repeat (6) @(posedge clock);
    enc_a <= ~enc_a;
    enc_b <= ~enc_b;
    repeat (2 * SC) @(posedge clock);
    check_read("double change", `ADDR_ACT_POS, pos_exp);
    check_read("sampled count", `ADDR_SAMPLE_POS, pos_exp);
    $display("test encoder done");
    // ****************************************
    // hold, buffered values, absolute move
    // ****************************************
    host.load_traj(16'h0000, 32'h0, 32'h0, 32'h0);
    host.start_move();
    check_read("hold desired", `ADDR_DESIRED, pos_exp);
    check_read("hold idle", `ADDR_CMD, 32'h0, 32'h2);
    tgt = 32'd40 + ($urandom % 60);
    host.load_traj(16'h0002, 32'h0, 32'h0, tgt);
    check_read("unstarted word", `ADDR_CTRL, 32'h0);
    check_read("unstarted desired", `ADDR_DESIRED, pos_exp);
    host.start_move();
    check_read("copied word", `ADDR_CTRL, 32'h2);
    check_read("zero accel hold", `ADDR_DESIRED, pos_exp);
    host.load_traj(16'h002A, 32'h00010000, 32'h00040000, tgt);
    host.start_move();
    do begin
      host.xfer(1'b0, `ADDR_CMD, 32'h0, rd);
    end while (rd[`ST_RUN] !== 1'b0);
    check_read("move end", `ADDR_DESIRED, tgt);
    $display("test move done");
    // ****************************************
    // stopping modes: abrupt during a move, smooth and off from rest
    // ****************************************
    host.load_traj(16'h0000, 32'h0, 32'h0, 32'h0);
    host.start_move();
    for (int i = 0; i < 3; i++) begin
      host.load_traj(stop_cw[i], 32'h0, 32'h0, 32'h0);
      host.start_move();
      if (i == 2) begin
        for (int k = 0; k < 3; k++) enc_step(1'b1);
      end
      check_read("stop desired", `ADDR_DESIRED, pos_exp);
      check_read("stop drive", `ADDR_CMD, drv_exp[i], 32'h8);
    end
    host.load_traj(16'h0000, 32'h0, 32'h0, 32'h0);
    host.start_move();
    check_read("drive back", `ADDR_CMD, 32'h8, 32'h8);
    $display("test stop done");
    finish_test();
  end
endmodule
